// File: vicl_pkg.sv
// Constants and types for the virtual interrupt control block loader
`default_nettype none
package vicl_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses (each 64-bit word split in two APB words; status is a single word)
   // ----------------------------------------------------------------
   localparam logic [11:0] VICL_CTRL_LO = 12'h060;
   localparam logic [11:0] VICL_CTRL_HI = 12'h064;
   localparam logic [11:0] VICL_BAR_LO  = 12'h098;
   localparam logic [11:0] VICL_BAR_HI  = 12'h09C;
   localparam logic [11:0] VICL_BACK_LO = 12'h0E0;
   localparam logic [11:0] VICL_BACK_HI = 12'h0E4;
   localparam logic [11:0] VICL_LOG_LO  = 12'h0F0;
   localparam logic [11:0] VICL_LOG_HI  = 12'h0F4;
   localparam logic [11:0] VICL_PHYS_LO = 12'h0F8;
   localparam logic [11:0] VICL_PHYS_HI = 12'h0FC;
   localparam logic [11:0] VICL_STATUS  = 12'h100;
   // ----------------------------------------------------------------
   // Field positions in the control word and pointer words
   // ----------------------------------------------------------------
   localparam int VICL_TPR_LSB   = 0;
   localparam int VICL_TPR_MSB   = 3;
   localparam int VICL_TPR_RSV_L = 4;
   localparam int VICL_TPR_RSV_H = 7;
   localparam int VICL_PEND_BIT  = 8;
   localparam int VICL_PRIO_LSB  = 16;
   localparam int VICL_PRIO_MSB  = 19;
   localparam int VICL_IGN_BIT   = 20;
   localparam int VICL_MASK_BIT  = 24;
   localparam int VICL_ACCEL_BIT = 31;
   localparam int VICL_VEC_LSB   = 32;
   localparam int VICL_VEC_MSB   = 39;
   localparam int VICL_PTR_LSB   = 12;
   localparam int VICL_PTR_MSB   = 51;
   localparam int VICL_MAXIDX_MSB = 7;
   // Highest legal physical address bit count of this implementation
   localparam int VICL_PA_BITS   = 48;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [63:0] VICL_WORD_RESET = 64'h0000_0000_0000_0000;
   localparam logic [31:0] VICL_ZERO32     = 32'h0000_0000;
   typedef enum logic [0:0] {
      VICL_HOST  = 1'b0,
      VICL_GUEST = 1'b1
   } vicl_state_t;
endpackage
`default_nettype wire

// File: vicl_loader.sv
// Guest control block virtual interrupt field loader with APB register access
//
// Chosen here: the APB register port.
`default_nettype none
module vicl_loader
   import vicl_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        guest_entry,
   input  wire logic        guest_exit,
   input  wire logic        tpr_wr,
   input  wire logic [7:0]  tpr_wdata,
   output logic             in_guest,
   output logic             entry_fault,
   output logic             accel_mode_enable,
   output logic [3:0]       virt_task_priority,
   output logic             virt_int_pending,
   output logic [3:0]       virt_int_priority,
   output logic             virt_ignore_priority,
   output logic             virt_int_masking,
   output logic [7:0]       virt_int_vector,
   output logic [39:0]      guest_intc_base,
   output logic [39:0]      backing_page_ptr,
   output logic [39:0]      logical_table_ptr,
   output logic [39:0]      physical_table_ptr,
   output logic [7:0]       physical_max_index
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Bits above the implemented physical width must be clear
   function automatic logic ptr_ok(input logic [63:0] p);
      return p[63:VICL_PA_BITS] == '0;
   endfunction

   function automatic logic [63:0] put_half(input logic [63:0] w, input logic hi, input logic [31:0] d);
      return hi ? {d, w[31:0]} : {w[63:32], d};
   endfunction

   vicl_state_t state;
   logic [63:0] ctrl_word;
   logic [63:0] bar_word;
   logic [63:0] back_word;
   logic [63:0] log_word;
   logic [63:0] phys_word;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire logic wr_xfer  = psel && penable && pwrite;
   wire logic hit_ctrl = paddr == VICL_CTRL_LO || paddr == VICL_CTRL_HI;
   wire logic hit_bar  = paddr == VICL_BAR_LO || paddr == VICL_BAR_HI;
   wire logic hit_back = paddr == VICL_BACK_LO || paddr == VICL_BACK_HI;
   wire logic hit_log  = paddr == VICL_LOG_LO || paddr == VICL_LOG_HI;
   wire logic hit_phys = paddr == VICL_PHYS_LO || paddr == VICL_PHYS_HI;
   wire logic hit_stat = paddr == VICL_STATUS;
   wire logic mapped   = hit_ctrl || hit_bar || hit_back || hit_log || hit_phys || hit_stat;
   wire logic hi_half  = paddr[2];

   assign pready  = penable;
   assign pslverr = psel && penable && !mapped;

   logic [63:0] rd_word;
   always_comb begin
      if (hit_ctrl) begin
         rd_word = ctrl_word;
      end else if (hit_bar) begin
         rd_word = bar_word;
      end else if (hit_back) begin
         rd_word = back_word;
      end else if (hit_log) begin
         rd_word = log_word;
      end else if (hit_phys) begin
         rd_word = phys_word;
      end else if (hit_stat) begin
         rd_word = {62'h0, entry_fault, in_guest};
      end else begin
         rd_word = VICL_WORD_RESET;
      end
   end

   // Read data is captured in the setup cycle so the access phase answers at once
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         prdata <= VICL_ZERO32;
      end else if (psel && !penable) begin
         prdata <= hi_half ? rd_word[63:32] : rd_word[31:0];
      end
   end

   // ----------------------------------------------------------------
   // Entry checks and sequencing
   // ----------------------------------------------------------------
   wire logic ptrs_ok  = ptr_ok(bar_word) && ptr_ok(back_word) && ptr_ok(log_word) && ptr_ok(phys_word);
   wire logic entry_go = guest_entry && state == VICL_HOST;
   wire logic entry_ok = entry_go && ptrs_ok;
   wire logic exit_go  = guest_exit && state == VICL_GUEST;
   wire logic accel_in = ctrl_word[VICL_ACCEL_BIT];
   // Accelerated mode suppresses the legacy injection fields at load
   wire logic legacy   = !accel_in;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state       <= VICL_HOST;
         entry_fault <= 1'b0;
      end else begin
         entry_fault <= entry_go && !ptrs_ok;
         case (state)
            VICL_HOST:  if (entry_ok) state <= VICL_GUEST;
            VICL_GUEST: if (exit_go) state <= VICL_HOST;
            default:    state <= VICL_HOST;
         endcase
      end
   end
   assign in_guest = state == VICL_GUEST;

   // ----------------------------------------------------------------
   // Control block words
   // ----------------------------------------------------------------
   // Exit write-back beats a software write landing in the same cycle
   logic [63:0] next_ctrl;
   always_comb begin
      next_ctrl = ctrl_word;
      if (wr_xfer && hit_ctrl) begin
         next_ctrl = put_half(ctrl_word, hi_half, pwdata);
      end
      if (exit_go) begin
         next_ctrl[VICL_TPR_MSB:VICL_TPR_LSB] = virt_task_priority;
         next_ctrl[VICL_PEND_BIT] = virt_int_pending;
      end
      next_ctrl[VICL_TPR_RSV_H:VICL_TPR_RSV_L] = 4'h0;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl_word <= VICL_WORD_RESET;
         bar_word  <= VICL_WORD_RESET;
         back_word <= VICL_WORD_RESET;
         log_word  <= VICL_WORD_RESET;
         phys_word <= VICL_WORD_RESET;
      end else begin
         ctrl_word <= next_ctrl;
         if (wr_xfer && hit_bar) bar_word <= put_half(bar_word, hi_half, pwdata);
         if (wr_xfer && hit_back) back_word <= put_half(back_word, hi_half, pwdata);
         if (wr_xfer && hit_log) log_word <= put_half(log_word, hi_half, pwdata);
         if (wr_xfer && hit_phys) phys_word <= put_half(phys_word, hi_half, pwdata);
      end
   end

   // ----------------------------------------------------------------
   // Fields latched at entry, all but task priority held through the guest run
   // ----------------------------------------------------------------
   // Loaded only on an accepted entry, so each virtual processor's own block decides
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         accel_mode_enable    <= 1'b0;
         virt_int_pending     <= 1'b0;
         virt_int_priority    <= 4'h0;
         virt_ignore_priority <= 1'b0;
         virt_int_masking     <= 1'b0;
         virt_int_vector      <= 8'h00;
         guest_intc_base      <= 40'h00_0000_0000;
         backing_page_ptr     <= 40'h00_0000_0000;
         logical_table_ptr    <= 40'h00_0000_0000;
         physical_table_ptr   <= 40'h00_0000_0000;
         physical_max_index   <= 8'h00;
      end else if (entry_ok) begin
         accel_mode_enable    <= accel_in;
         virt_int_pending     <= legacy && ctrl_word[VICL_PEND_BIT];
         virt_int_priority    <= legacy ? ctrl_word[VICL_PRIO_MSB:VICL_PRIO_LSB] : 4'h0;
         virt_ignore_priority <= legacy && ctrl_word[VICL_IGN_BIT];
         virt_int_vector      <= legacy ? ctrl_word[VICL_VEC_MSB:VICL_VEC_LSB] : 8'h00;
         virt_int_masking     <= ctrl_word[VICL_MASK_BIT];
         guest_intc_base      <= bar_word[VICL_PTR_MSB:VICL_PTR_LSB];
         backing_page_ptr     <= back_word[VICL_PTR_MSB:VICL_PTR_LSB];
         logical_table_ptr    <= log_word[VICL_PTR_MSB:VICL_PTR_LSB];
         physical_table_ptr   <= phys_word[VICL_PTR_MSB:VICL_PTR_LSB];
         physical_max_index   <= phys_word[VICL_MAXIDX_MSB:0];
      end
   end

   // Task priority: loaded at entry, then tracks guest task priority writes
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         virt_task_priority <= 4'h0;
      end else if (entry_ok) begin
         virt_task_priority <= ctrl_word[VICL_TPR_MSB:VICL_TPR_LSB];
      end else if (in_guest && tpr_wr) begin
         virt_task_priority <= tpr_wdata[7:4];
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   property p_accel_load;
      entry_ok |=> accel_mode_enable == $past(ctrl_word[VICL_ACCEL_BIT]);
   endproperty
   a_accel_load: assert property (p_accel_load) else $error("accel enable not loaded");

   property p_tpr_rsv;
      ##1 ctrl_word[VICL_TPR_RSV_H:VICL_TPR_RSV_L] == 4'h0;
   endproperty
   a_tpr_rsv: assert property (p_tpr_rsv) else $error("priority reserved bits set");

   property p_writeback;
      exit_go |=> ctrl_word[VICL_TPR_MSB:VICL_TPR_LSB] == $past(virt_task_priority)
                  && ctrl_word[VICL_PEND_BIT] == $past(virt_int_pending);
   endproperty
   a_writeback: assert property (p_writeback) else $error("exit write-back wrong");

   property p_pending;
      entry_ok && !accel_in |=> virt_int_pending == $past(ctrl_word[VICL_PEND_BIT]);
   endproperty
   a_pending: assert property (p_pending) else $error("pending flag not loaded");

   property p_decode;
      entry_ok && !accel_in |=> virt_int_vector == $past(ctrl_word[VICL_VEC_MSB:VICL_VEC_LSB])
         && virt_int_priority == $past(ctrl_word[VICL_PRIO_MSB:VICL_PRIO_LSB])
         && virt_ignore_priority == $past(ctrl_word[VICL_IGN_BIT]);
   endproperty
   a_decode: assert property (p_decode) else $error("interrupt fields wrong");

   property p_masking;
      entry_ok |=> virt_int_masking == $past(ctrl_word[VICL_MASK_BIT]);
   endproperty
   a_masking: assert property (p_masking) else $error("masking not loaded");

   property p_accel_ignore;
      entry_ok && accel_in |=> !virt_int_pending && !virt_ignore_priority
                                && virt_int_vector == 8'h00 && virt_int_priority == 4'h0;
   endproperty
   a_accel_ignore: assert property (p_accel_ignore) else $error("legacy fields used");

   property p_bar;
      entry_ok |=> guest_intc_base == $past(bar_word[VICL_PTR_MSB:VICL_PTR_LSB]);
   endproperty
   a_bar: assert property (p_bar) else $error("base address wrong");

   property p_page_ptrs;
      entry_ok |=> backing_page_ptr == $past(back_word[VICL_PTR_MSB:VICL_PTR_LSB])
                   && logical_table_ptr == $past(log_word[VICL_PTR_MSB:VICL_PTR_LSB]);
   endproperty
   a_page_ptrs: assert property (p_page_ptrs) else $error("page pointers wrong");

   property p_tables;
      entry_ok |=> physical_max_index == $past(phys_word[VICL_MAXIDX_MSB:0])
                   && physical_table_ptr == $past(phys_word[VICL_PTR_MSB:VICL_PTR_LSB]);
   endproperty
   a_tables: assert property (p_tables) else $error("physical table fields wrong");

   property p_fault;
      entry_go && !ptrs_ok |=> entry_fault && !in_guest ##1 !entry_fault;
   endproperty
   a_fault: assert property (p_fault) else $error("bad pointer entered guest");

   property p_tpr_copy;
      in_guest && tpr_wr |=> virt_task_priority == $past(tpr_wdata[7:4]);
   endproperty
   a_tpr_copy: assert property (p_tpr_copy) else $error("task priority not copied");

   property p_hold;
      in_guest && !exit_go |=> $stable(virt_int_vector) && $stable(backing_page_ptr)
                               && $stable(accel_mode_enable) && in_guest;
   endproperty
   a_hold: assert property (p_hold) else $error("latched field changed");

   c_accel: cover property (entry_ok && accel_in ##[1:20] exit_go);
   c_legacy: cover property (entry_ok && !accel_in && ctrl_word[VICL_PEND_BIT]);
   c_fault: cover property (entry_go && !ptrs_ok);
   c_tpr_exit: cover property (in_guest && tpr_wr ##[1:10] exit_go);
endmodule // vicl_loader
`default_nettype wire

// File: vicl_hv_model.sv
// Hypervisor-side model that fills the guest control block over APB
`default_nettype none
module vicl_hv_model
   import vicl_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata
);
   timeunit 1ns;
   timeprecision 100ps;
   int slow   = 0;
   int stalls = 0;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   // -------------------------------------------------------------
   // Bus transfer
   // -------------------------------------------------------------
   // Pointers stay page aligned; one control write sets reserved priority bits to show they drop
   // Nested paging, write-back mapping, base register intercepts and
   // translation flushes live outside this block's ports
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      int n;
      repeat (slow) @(posedge sys_clk);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      if (n == 16) stalls++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines do not keep showing the old value
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule // vicl_hv_model
`default_nettype wire

// File: vicl_loader_tb.sv
// Self-checking testbench for the guest control block loader
`default_nettype none
module vicl_loader_tb
   import vicl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic        guest_entry, guest_exit, tpr_wr, in_guest, entry_fault;
   logic        accel, pend, ign, mask;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  tpr_wdata, vec, maxidx;
   logic [3:0]  vtp, prio;
   logic [39:0] bar, back, logt, phyt;
   logic [11:0] hi_addr [4] = '{VICL_BAR_HI, VICL_BACK_HI, VICL_LOG_HI, VICL_PHYS_HI};
   logic [31:0] hi_val  [4] = '{32'h0000_ABCD, 32'h0000_0001, 32'h0000_FFFF, 32'h0000_0002};
   int          fails = 0;
   int          checked = 0;

   always #2.5 sys_clk = ~sys_clk;

   vicl_hv_model u_vicl_hv_model (.sys_clk(sys_clk), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata));
   vicl_loader u_vicl_loader (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .guest_entry(guest_entry), .guest_exit(guest_exit), .tpr_wr(tpr_wr),
      .tpr_wdata(tpr_wdata), .in_guest(in_guest), .entry_fault(entry_fault),
      .accel_mode_enable(accel), .virt_task_priority(vtp), .virt_int_pending(pend),
      .virt_int_priority(prio), .virt_ignore_priority(ign), .virt_int_masking(mask),
      .virt_int_vector(vec), .guest_intc_base(bar), .backing_page_ptr(back),
      .logical_table_ptr(logt), .physical_table_ptr(phyt), .physical_max_index(maxidx));

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic print_verdict;
      if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      u_vicl_hv_model.xfer(1'b1, a, d, q, e);
      if (u_vicl_hv_model.stalls != 0) begin
         fails++;
         print_verdict();
      end
   endtask
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic        e;
      u_vicl_hv_model.xfer(1'b0, a, 32'h0000_0000, q, e);
      if (u_vicl_hv_model.stalls != 0) begin
         fails++;
         print_verdict();
      end
      chk(nm, q, x);
      chk("pslverr", e, xe);
   endtask
   task automatic pulse(input int k, input logic [7:0] d);
      @(posedge sys_clk);
      guest_entry <= (k == 0);
      guest_exit <= (k == 1);
      tpr_wr <= (k == 2);
      tpr_wdata <= d;
      @(posedge sys_clk);
      guest_entry <= 1'b0;
      guest_exit <= 1'b0;
      tpr_wr <= 1'b0;
      #1;
   endtask
   task automatic enter(input logic f);
      int n;
      pulse(0, 8'h00);
      for (n = 0; n < 8 && in_guest !== 1'b1 && entry_fault !== 1'b1; n++) @(posedge sys_clk) #1;
      chk("entry_fault", entry_fault, f);
      chk("in_guest", in_guest, !f);
      if (n == 8) begin
         fails++;
         print_verdict();
      end
      if (f) begin
         @(posedge sys_clk) #1;
         chk("fault_pulse", entry_fault, 1'b0);
      end
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      reset = 1'b1;
      guest_entry = 1'b0;
      guest_exit = 1'b0;
      tpr_wr = 1'b0;
      tpr_wdata = 8'h00;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      rd("ctrl_reset", VICL_CTRL_LO, 32'h0000_0000, 1'b0);
      rd("status_reset", VICL_STATUS, 32'h0000_0000, 1'b0);
      rd("unmapped", 12'h010, 32'h0000_0000, 1'b1);
      // Slow master for the fill, prompt afterwards
      u_vicl_hv_model.slow = 2;
      wr(VICL_CTRL_LO, 32'h011A_01F5);
      wr(VICL_CTRL_HI, 32'h0000_00C3);
      wr(VICL_BAR_LO, 32'h1234_5000);
      wr(VICL_BACK_LO, 32'h2222_3000);
      wr(VICL_LOG_LO, 32'h4444_5000);
      wr(VICL_PHYS_LO, 32'h6666_7042);
      for (int i = 0; i < 4; i++) wr(hi_addr[i], hi_val[i]);
      u_vicl_hv_model.slow = 0;
      rd("ctrl_tpr", VICL_CTRL_LO, 32'h011A_0105, 1'b0);
      enter(1'b0);
      chk("accel", accel, 1'b0);
      chk("pending", pend, 1'b1);
      chk("prio", prio, 4'hA);
      chk("ignore", ign, 1'b1);
      chk("vector", vec, 8'hC3);
      chk("masking", mask, 1'b1);
      chk("tpr", vtp, 4'h5);
      chk("intc_base", bar, 40'h0ABCD_12345);
      chk("backing", back, 40'h00001_22223);
      chk("logical", logt, 40'h0FFFF_44445);
      chk("physical", phyt, 40'h00002_66667);
      chk("max_index", maxidx, 8'h42);
      rd("status_in", VICL_STATUS, 32'h0000_0001, 1'b0);
      wr(VICL_CTRL_LO, 32'h0000_0000);
      wr(VICL_CTRL_HI, 32'h0000_0000);
      chk("held_mask", mask, 1'b1);
      chk("held_vec", vec, 8'hC3);
      pulse(2, 8'h9C);
      chk("tpr_write", vtp, 4'h9);
      pulse(1, 8'h00);
      chk("exit", in_guest, 1'b0);
      rd("writeback", VICL_CTRL_LO, 32'h0000_0109, 1'b0);
      wr(VICL_CTRL_LO, 32'h811F_0107);
      wr(VICL_CTRL_HI, 32'h0000_005A);
      enter(1'b0);
      chk("accel_on", accel, 1'b1);
      chk("acc_pend", pend, 1'b0);
      chk("acc_prio", prio, 4'h0);
      chk("acc_ign", ign, 1'b0);
      chk("acc_vec", vec, 8'h00);
      chk("acc_mask", mask, 1'b1);
      chk("acc_tpr", vtp, 4'h7);
      pulse(1, 8'h00);
      rd("acc_wb", VICL_CTRL_LO, 32'h811F_0007, 1'b0);
      wr(VICL_CTRL_LO, 32'h0000_0003);
      enter(1'b0);
      chk("accel_off", accel, 1'b0);
      pulse(1, 8'h00);
      // Each pointer in turn beyond the legal physical range
      for (int i = 0; i < 4; i++) begin
         wr(hi_addr[i], 32'h0001_0000);
         enter(1'b1);
         wr(hi_addr[i], hi_val[i]);
      end
      chk("bus_stalls", u_vicl_hv_model.stalls, 0);
      print_verdict();
   end
endmodule // vicl_loader_tb
`default_nettype wire
